// ---- verilog/sts_pkg.sv ----
// Constants and carrier types of the status, error queue and self-test reporting block.
package sts_pkg;

	// ----------------------------------------
	// Questionable group bit positions
	// ----------------------------------------
	localparam int Q_OVERLOAD = 0;
	localparam int Q_CAL_FAIL = 8;
	localparam int Q_LIMIT_LO = 9;
	localparam int LIMIT_CHANNELS = 4;
	localparam logic [15:0] LIMIT_MASK = 16'h1e00;

	// ----------------------------------------
	// Operation group bit positions
	// ----------------------------------------
	localparam int O_CAL_BUSY = 0;
	localparam int O_WAIT_TRIG = 5;
	localparam int O_PRETRIG_MET = 8;
	localparam int O_MEAS_DONE = 9;

	// ----------------------------------------
	// Summary status byte bit positions
	// ----------------------------------------
	localparam int SB_OPER = 7;
	localparam int SB_RQS = 6;
	localparam int SB_ESB = 5;
	localparam int SB_MAV = 4;
	localparam int SB_QUES = 3;

	// ----------------------------------------
	// Reset values, queue and self-test figures
	// ----------------------------------------
	localparam logic [15:0] REG16_RESET = 16'h0000;
	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam int EQ_DEPTH = 20;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
	localparam logic [7:0] MSG_NO_ERROR = 8'h00;
	localparam logic [7:0] MSG_TOO_MANY = 8'h01;
	localparam int TEST_COUNT = 94;
	localparam logic [6:0] TEST_FIRST = 7'h01;
	localparam logic [6:0] TEST_LAST = 7'h5e;
	localparam logic [14:0] CYCLES_MIN = 15'h0001;
	localparam logic [14:0] CYCLES_MAX = 15'h7fff;
	localparam logic [15:0] VERSION_YEAR = 16'h07d0;
	localparam logic [3:0] VERSION_REV = 4'h0;

	// ----------------------------------------
	// Commands
	// ----------------------------------------
	typedef enum logic [4:0] {
		CMD_OPER_COND = 5'h00,
		CMD_OPER_EVENT = 5'h01,
		CMD_OPER_ENAB_WR = 5'h02,
		CMD_OPER_ENAB_RD = 5'h03,
		CMD_QUES_COND = 5'h04,
		CMD_QUES_EVENT = 5'h05,
		CMD_QUES_ENAB_WR = 5'h06,
		CMD_QUES_ENAB_RD = 5'h07,
		CMD_PRESET = 5'h08,
		CMD_STB_RD = 5'h09,
		CMD_ESR_RD = 5'h0a,
		CMD_ESE_WR = 5'h0b,
		CMD_ESE_RD = 5'h0c,
		CMD_SRE_WR = 5'h0d,
		CMD_SRE_RD = 5'h0e,
		CMD_CLS = 5'h0f,
		CMD_ERR_RD = 5'h10,
		CMD_VERSION = 5'h11,
		CMD_SELFTEST = 5'h12,
		CMD_TST_RESULTS = 5'h13,
		CMD_TEST_ERR = 5'h14,
		CMD_TEST_NUM = 5'h15
	} sts_cmd_code_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_WAIT = 2'b10
	} sts_test_state_type;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		sts_cmd_code_type code;
		logic [31:0] arg;
	} sts_cmd_type;

	typedef struct packed {
		logic valid;
		logic range_err;
		logic [31:0] data;
		logic [31:0] aux;
	} sts_resp_type;

	typedef struct packed {
		logic overload;
		logic cal_fail;
		logic [LIMIT_CHANNELS-1:0] limit_fail;
		logic cal_busy;
		logic wait_trig;
		logic pretrig_met;
		logic meas_done;
		logic cycle_end;
	} sts_meas_type;

	typedef struct packed {
		logic [15:0] num;
		logic [7:0] msg;
	} sts_err_type;

	typedef struct packed {
		logic done;
		logic [7:0] mode;
		logic [31:0] param;
	} sts_test_result_type;

endpackage

// ---- verilog/sts_status_unit.sv ----
// Status register groups, error queue and self-test bookkeeping behind the command port.
`timescale 1ns/1ps

// How it works
// - Questionable condition: overload bit 0, calibration failure bit 8, limits bits 9-12.
// - Limit conditions follow samples; event captures them once per measurement cycle.
// - Operation condition: calibrating 0, awaiting trigger 5, pretrigger met 8, done 9.
// - Status byte: operation 7, request 6, standard event 5, message 4, questionable 3.
// - Status byte bit 7 is the OR of enabled operation event bits.
// - Status byte bit 3 is the OR of enabled questionable event bits.
// - Operation events count toward the status byte only when enabled by a write.
// - Questionable events count toward bit 3 only when enabled.
// - Reading an event register returns its bits and clears all of them except bits set by an event in the same cycle.
// - Reading a condition register returns the live condition bits.
// - Preset zeroes both enable registers and leaves every other register alone.
// - Enabled standard event bits are ORed into status byte bit 5.
// - The status byte is answered only once earlier commands have finished.
// - Errors queue as number plus message; a query returns and removes the oldest.
// - An empty queue answers error zero with the no-error message.
// - Twenty entries; overflow turns the newest into -350 and drops further errors.
// - Clear-status empties the whole error queue at once.
// - Repeat test takes test 1-94, cycles 1-32767, returns the failure count.
// - Full self-test reports the first failure; results query returns the next failure at or after a given test.
// - Per-test query returns the failure-mode byte and the test parameter word.
// - Version query returns the year and the revision within that year.
module sts_status_unit (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Command port
	input wire sts_pkg::sts_cmd_type cmd_i,
	output logic cmd_ready_o,
	output sts_pkg::sts_resp_type resp_o,
	// Measurement datapath conditions and events
	input wire sts_pkg::sts_meas_type meas_i,
	input wire logic [7:0] std_event_i,
	input wire logic mav_i,
	input wire sts_pkg::sts_err_type err_i,
	input wire logic err_valid_i,
	// Self-test engine
	output logic test_start_o,
	output logic [6:0] test_num_o,
	input wire sts_pkg::sts_test_result_type test_i,
	// Status byte
	output logic [7:0] stb_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] q_cond_d;
		logic [15:0] o_cond_d;
		logic [15:0] q_event;
		logic [15:0] q_enable;
		logic [15:0] o_event;
		logic [15:0] o_enable;
		logic [sts_pkg::LIMIT_CHANNELS-1:0] limit_seen;
		logic [7:0] esr;
		logic [7:0] ese;
		logic [7:0] sre;
		logic [7:0] stb;
		sts_pkg::sts_err_type [sts_pkg::EQ_DEPTH-1:0] eq;
		logic [4:0] eq_count;
		logic eq_ovf;
		sts_pkg::sts_test_state_type st;
		logic run_all;
		logic [6:0] cur_test;
		logic [14:0] cycles_left;
		logic [15:0] fail_cnt;
		logic [6:0] first_fail;
		logic [sts_pkg::TEST_COUNT-1:0] fail_map;
		logic [sts_pkg::TEST_COUNT-1:0][7:0] modes;
		logic [sts_pkg::TEST_COUNT-1:0][31:0] params;
		logic start;
		sts_pkg::sts_resp_type resp;
	} sts_unit_state_type;

	sts_unit_state_type s;
	sts_unit_state_type next_s;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic test_in_range(input logic [6:0] num);
		test_in_range = (num >= sts_pkg::TEST_FIRST) && (num <= sts_pkg::TEST_LAST);
	endfunction

	function automatic logic [6:0] next_failure(input logic [sts_pkg::TEST_COUNT-1:0] map,
			input logic [6:0] from);
		next_failure = 7'h00;
		for (int i = sts_pkg::TEST_COUNT - 1; i >= 0; i--) begin
			if (map[i] && (7'(i + 1) >= from)) begin
				next_failure = 7'(i + 1);
			end
		end
	endfunction

	logic [15:0] q_cond;
	logic [15:0] o_cond;
	logic [15:0] q_set;
	logic [15:0] o_set;
	logic [7:0] stb_now;
	logic accept;
	logic [6:0] arg_test;
	logic [14:0] arg_cycles;
	logic [6:0] idx;
	logic [4:0] cnt;
	logic fail;

	assign accept = cmd_i.valid && (s.st == sts_pkg::ST_IDLE);
	assign cmd_ready_o = (s.st == sts_pkg::ST_IDLE);
	assign arg_test = cmd_i.arg[22:16];
	assign arg_cycles = cmd_i.arg[14:0];
	assign resp_o = s.resp;
	assign test_start_o = s.start;
	assign test_num_o = s.cur_test;
	assign stb_o = s.stb;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.resp = '0;
		next_s.start = 1'b0;
		cnt = s.eq_count;
		idx = 7'(s.cur_test - 7'h01);
		fail = (test_i.mode != 8'h00);

		q_cond = sts_pkg::REG16_RESET;
		q_cond[sts_pkg::Q_OVERLOAD] = meas_i.overload;
		q_cond[sts_pkg::Q_CAL_FAIL] = meas_i.cal_fail;
		q_cond[sts_pkg::Q_LIMIT_LO +: sts_pkg::LIMIT_CHANNELS] = meas_i.limit_fail;
		o_cond = sts_pkg::REG16_RESET;
		o_cond[sts_pkg::O_CAL_BUSY] = meas_i.cal_busy;
		o_cond[sts_pkg::O_WAIT_TRIG] = meas_i.wait_trig;
		o_cond[sts_pkg::O_PRETRIG_MET] = meas_i.pretrig_met;
		o_cond[sts_pkg::O_MEAS_DONE] = meas_i.meas_done;
		next_s.q_cond_d = q_cond;
		next_s.o_cond_d = o_cond;

		// Limit bits toggle at the sample rate, so a rising edge would miss a failure
		// that is already present; they are gathered over the whole cycle instead.
		next_s.limit_seen = meas_i.cycle_end ? '0 : (s.limit_seen | meas_i.limit_fail);
		q_set = q_cond & ~s.q_cond_d & ~sts_pkg::LIMIT_MASK;
		if (meas_i.cycle_end) begin
			q_set[sts_pkg::Q_LIMIT_LO +: sts_pkg::LIMIT_CHANNELS] =
				s.limit_seen | meas_i.limit_fail;
		end
		o_set = o_cond & ~s.o_cond_d;

		// A new event in the clearing cycle survives the read.
		next_s.q_event = s.q_event | q_set;
		next_s.o_event = s.o_event | o_set;
		next_s.esr = s.esr | std_event_i;

		// The status byte is rebuilt every cycle from the registered events and enables,
		// so it lags a new event by one clock; the request bit uses the same copy.
		stb_now = sts_pkg::REG8_RESET;
		stb_now[sts_pkg::SB_OPER] = |(s.o_event & s.o_enable);
		stb_now[sts_pkg::SB_QUES] = |(s.q_event & s.q_enable);
		stb_now[sts_pkg::SB_ESB] = |(s.esr & s.ese);
		stb_now[sts_pkg::SB_MAV] = mav_i;
		stb_now[sts_pkg::SB_RQS] = |(stb_now & s.sre & ~(8'h01 << sts_pkg::SB_RQS));
		next_s.stb = stb_now;

		// ----------------------------------------
		// Command decode
		// ----------------------------------------
		if (accept) begin
			next_s.resp.valid = 1'b1;
			case (cmd_i.code)
				sts_pkg::CMD_OPER_COND: begin
					next_s.resp.data = {16'h0000, o_cond};
				end
				sts_pkg::CMD_QUES_COND: begin
					next_s.resp.data = {16'h0000, q_cond};
				end
				sts_pkg::CMD_OPER_EVENT: begin
					next_s.resp.data = {16'h0000, s.o_event};
					next_s.o_event = o_set;
				end
				sts_pkg::CMD_QUES_EVENT: begin
					next_s.resp.data = {16'h0000, s.q_event};
					next_s.q_event = q_set;
				end
				sts_pkg::CMD_OPER_ENAB_WR: begin
					next_s.o_enable = cmd_i.arg[15:0];
				end
				sts_pkg::CMD_QUES_ENAB_WR: begin
					next_s.q_enable = cmd_i.arg[15:0];
				end
				sts_pkg::CMD_OPER_ENAB_RD: begin
					next_s.resp.data = {16'h0000, s.o_enable};
				end
				sts_pkg::CMD_QUES_ENAB_RD: begin
					next_s.resp.data = {16'h0000, s.q_enable};
				end
				sts_pkg::CMD_PRESET: begin
					next_s.o_enable = sts_pkg::REG16_RESET;
					next_s.q_enable = sts_pkg::REG16_RESET;
				end
				sts_pkg::CMD_STB_RD: begin
					// Only taken while idle, so every earlier command has completed.
					next_s.resp.data = {24'h000000, stb_now};
				end
				sts_pkg::CMD_ESR_RD: begin
					next_s.resp.data = {24'h000000, s.esr};
					next_s.esr = std_event_i;
				end
				sts_pkg::CMD_ESE_WR: begin
					next_s.ese = cmd_i.arg[7:0];
				end
				sts_pkg::CMD_ESE_RD: begin
					next_s.resp.data = {24'h000000, s.ese};
				end
				sts_pkg::CMD_SRE_WR: begin
					next_s.sre = cmd_i.arg[7:0];
				end
				sts_pkg::CMD_SRE_RD: begin
					next_s.resp.data = {24'h000000, s.sre};
				end
				sts_pkg::CMD_CLS: begin
					next_s.esr = std_event_i;
					next_s.q_event = q_set;
					next_s.o_event = o_set;
					cnt = 5'h00;
					next_s.eq_ovf = 1'b0;
				end
				sts_pkg::CMD_ERR_RD: begin
					if (s.eq_count == 5'h00) begin
						next_s.resp.data = {16'h0000, sts_pkg::ERR_NONE};
						next_s.resp.aux = {24'h000000, sts_pkg::MSG_NO_ERROR};
					end else begin
						next_s.resp.data = {{16{s.eq[0].num[15]}}, s.eq[0].num};
						next_s.resp.aux = {24'h000000, s.eq[0].msg};
						// A pop shifts every entry toward slot 0, so the oldest is always at the head.
						// This costs a mux per slot but keeps the answer a plain register read.
						for (int i = 0; i < sts_pkg::EQ_DEPTH - 1; i++) begin
							next_s.eq[i] = s.eq[i + 1];
						end
						next_s.eq[sts_pkg::EQ_DEPTH-1] = '0;
						cnt = 5'(s.eq_count - 5'h01);
						next_s.eq_ovf = 1'b0;
					end
				end
				sts_pkg::CMD_VERSION: begin
					next_s.resp.data = {16'h0000, sts_pkg::VERSION_YEAR};
					next_s.resp.aux = {28'h0000000, sts_pkg::VERSION_REV};
				end
				sts_pkg::CMD_SELFTEST: begin
					next_s.resp.valid = 1'b0;
					next_s.run_all = 1'b1;
					next_s.cur_test = sts_pkg::TEST_FIRST;
					next_s.first_fail = 7'h00;
					next_s.fail_map = '0;
					next_s.st = sts_pkg::ST_START;
				end
				sts_pkg::CMD_TST_RESULTS: begin
					next_s.resp.data = {25'h0000000, next_failure(s.fail_map, cmd_i.arg[6:0])};
					next_s.resp.aux = {25'h0000000, s.first_fail};
				end
				sts_pkg::CMD_TEST_ERR: begin
					if (test_in_range(arg_test)) begin
						next_s.resp.data = {24'h000000, s.modes[7'(arg_test - 7'h01)]};
						next_s.resp.aux = s.params[7'(arg_test - 7'h01)];
					end else begin
						next_s.resp.range_err = 1'b1;
					end
				end
				sts_pkg::CMD_TEST_NUM: begin
					if (test_in_range(arg_test) && (arg_cycles >= sts_pkg::CYCLES_MIN)
							&& (arg_cycles <= sts_pkg::CYCLES_MAX)) begin
						next_s.resp.valid = 1'b0;
						next_s.run_all = 1'b0;
						next_s.cur_test = arg_test;
						next_s.cycles_left = arg_cycles;
						next_s.fail_cnt = 16'h0000;
						next_s.st = sts_pkg::ST_START;
					end else begin
						next_s.resp.range_err = 1'b1;
					end
				end
				default: begin
					next_s.resp.range_err = 1'b1;
				end
			endcase
		end

		// ----------------------------------------
		// Error queue filling
		// ----------------------------------------
		// An error arriving with a clear or a pop is still stored.
		// The overflow mark keeps the marker entry in the last slot until a pop frees room;
		// without it every further push would overwrite the marker.
		if (err_valid_i) begin
			if (cnt < 5'(sts_pkg::EQ_DEPTH)) begin
				next_s.eq[cnt] = err_i;
				cnt = 5'(cnt + 5'h01);
			end else if (!next_s.eq_ovf) begin
				next_s.eq[sts_pkg::EQ_DEPTH-1].num = sts_pkg::ERR_OVERFLOW;
				next_s.eq[sts_pkg::EQ_DEPTH-1].msg = sts_pkg::MSG_TOO_MANY;
				next_s.eq_ovf = 1'b1;
			end
		end
		next_s.eq_count = cnt;

		// ----------------------------------------
		// Self-test sequencing
		// ----------------------------------------
		// Each run is launched by a one-cycle start pulse and its result is taken with done.
		// A done pulse outside the wait state is ignored, so a stray pulse cannot shift results.
		case (s.st)
			sts_pkg::ST_IDLE: begin
			end
			sts_pkg::ST_START: begin
				next_s.start = 1'b1;
				next_s.st = sts_pkg::ST_WAIT;
			end
			sts_pkg::ST_WAIT: begin
				if (test_i.done) begin
					next_s.modes[idx] = test_i.mode;
					next_s.params[idx] = test_i.param;
					if (s.run_all) begin
						next_s.fail_map[idx] = fail;
						if (fail && (s.first_fail == 7'h00)) begin
							next_s.first_fail = s.cur_test;
						end
						if (s.cur_test == sts_pkg::TEST_LAST) begin
							next_s.st = sts_pkg::ST_IDLE;
							next_s.resp.valid = 1'b1;
							next_s.resp.data = {25'h0000000,
								(fail && (s.first_fail == 7'h00)) ? s.cur_test : s.first_fail};
						end else begin
							next_s.cur_test = 7'(s.cur_test + 7'h01);
							next_s.st = sts_pkg::ST_START;
						end
					end else begin
						next_s.fail_cnt = 16'(s.fail_cnt + {15'h0000, fail});
						next_s.cycles_left = 15'(s.cycles_left - 15'h0001);
						if (s.cycles_left == 15'h0001) begin
							next_s.st = sts_pkg::ST_IDLE;
							next_s.resp.valid = 1'b1;
							next_s.resp.data = {16'h0000, 16'(s.fail_cnt + {15'h0000, fail})};
						end else begin
							next_s.st = sts_pkg::ST_START;
						end
					end
				end
			end
			default: begin
				next_s.st = sts_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// The whole state, result tables included, resets to zero, so a results query
	// before any self-test reports no failures.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

// ---- testbench/sts_status_unit_properties.sv ----
// Concurrent checks on the command port and status byte of the status unit.
`timescale 1ns/1ps
module sts_status_unit_props (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Command port
	input wire sts_pkg::sts_cmd_type cmd_i,
	input wire logic cmd_ready_o,
	input wire sts_pkg::sts_resp_type resp_o,
	// Conditions, self-test and status byte
	input wire sts_pkg::sts_meas_type meas_i,
	input wire logic mav_i,
	input wire logic test_start_o,
	input wire logic [6:0] test_num_o,
	input wire logic [7:0] stb_o
);
	default clocking dcb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire take = cmd_i.valid && cmd_ready_o;

	property p_oper_cond;
		take && cmd_i.code == sts_pkg::CMD_OPER_COND && $stable(meas_i) |=> resp_o.valid &&
			resp_o.data[9:0] == {$past(meas_i.meas_done), $past(meas_i.pretrig_met), 2'h0,
			$past(meas_i.wait_trig), 4'h0, $past(meas_i.cal_busy)};
	endproperty
	a_oper_cond: assert property (p_oper_cond) else $error("operation condition answer wrong");
	property p_ques_cond;
		take && cmd_i.code == sts_pkg::CMD_QUES_COND && $stable(meas_i) |=> resp_o.valid &&
			resp_o.data[12:0] == {$past(meas_i.limit_fail), $past(meas_i.cal_fail), 7'h00, $past(meas_i.overload)};
	endproperty
	a_ques_cond: assert property (p_ques_cond) else $error("questionable condition answer wrong");
	property p_version;
		take && cmd_i.code == sts_pkg::CMD_VERSION |=> resp_o.valid &&
			resp_o.data[15:0] == sts_pkg::VERSION_YEAR && resp_o.aux[3:0] == sts_pkg::VERSION_REV;
	endproperty
	a_version: assert property (p_version) else $error("version answer wrong");
	property p_test_start;
		take && cmd_i.code == sts_pkg::CMD_TEST_NUM && cmd_i.arg[22:16] inside {[7'h01:7'h5e]} &&
			cmd_i.arg[14:0] != 15'h0000 |-> ##2 test_start_o && test_num_o == $past(cmd_i.arg[22:16], 2);
	endproperty
	a_test_start: assert property (p_test_start) else $error("repeat test did not start");
	property p_test_range;
		take && cmd_i.code == sts_pkg::CMD_TEST_NUM && cmd_i.arg[22:16] > 7'h5e |=>
			resp_o.valid && resp_o.range_err && !test_start_o;
	endproperty
	a_test_range: assert property (p_test_range) else $error("bad test number accepted");
	property p_busy;
		test_start_o |-> !cmd_ready_o;
	endproperty
	a_busy: assert property (p_busy) else $error("ready while a test runs");
	property p_rqs;
		stb_o[6] |-> (stb_o & 8'hbf) != 8'h00;
	endproperty
	a_rqs: assert property (p_rqs) else $error("request bit without a cause");
	property p_mav;
		$rose(mav_i) |-> ##[1:2] stb_o[4];
	endproperty
	a_mav: assert property (p_mav) else $error("message bit missing");
	property p_preset;
		take && cmd_i.code == sts_pkg::CMD_PRESET |=> resp_o.valid && resp_o.data == 32'h00000000;
	endproperty
	a_preset: assert property (p_preset) else $error("preset answer wrong");
	property p_stb_answer;
		take && cmd_i.code == sts_pkg::CMD_STB_RD |=> resp_o.valid && !resp_o.range_err;
	endproperty
	a_stb_answer: assert property (p_stb_answer) else $error("status byte not answered");
endmodule

bind sts_status_unit sts_status_unit_props i_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .resp_o(resp_o), .meas_i(meas_i), .mav_i(mav_i),
	.test_start_o(test_start_o), .test_num_o(test_num_o), .stb_o(stb_o));

// ---- testbench/sts_status_unit_bench.sv ----
// Self-checking bench for the status unit.
`timescale 1ns/1ps
module sts_status_unit_bench;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	sts_pkg::sts_cmd_type cmd_i = '0;
	logic cmd_ready_o;
	sts_pkg::sts_resp_type resp_o;
	sts_pkg::sts_meas_type meas_i = '0;
	logic [7:0] std_event_i = 8'h00;
	logic mav_i = 1'b0;
	sts_pkg::sts_err_type err_i = '0;
	logic err_valid_i = 1'b0;
	logic test_start_o;
	logic [6:0] test_num_o;
	sts_pkg::sts_test_result_type test_i = '0;
	logic [7:0] stb_o;
	int error_cnt = 0;
	int n_tests = 0;
	int pend = 0;
	logic [31:0] rd;
	logic [31:0] rx;
	logic rr;

	sts_status_unit i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i),
		.cmd_ready_o(cmd_ready_o), .resp_o(resp_o), .meas_i(meas_i), .std_event_i(std_event_i),
		.mav_i(mav_i), .err_i(err_i), .err_valid_i(err_valid_i), .test_start_o(test_start_o),
		.test_num_o(test_num_o), .test_i(test_i), .stb_o(stb_o));

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Self-test engine stand-in: tests 2 and 40 fail with mode 5.
	always @(negedge core_clk_i) begin
		test_i.done = 1'b0;
		if (pend == 1) begin
			test_i.done = 1'b1;
			test_i.mode = (test_num_o == 7'h02 || test_num_o == 7'h28) ? 8'h05 : 8'h00;
			test_i.param = {25'h0, test_num_o} | 32'h00ab0000;
		end
		if (pend > 0)
			pend = pend - 1;
		if (test_start_o)
			pend = 3;
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Called at a falling edge; the request is held until the edge that takes it.
	task automatic send(input sts_pkg::sts_cmd_code_type code, input logic [31:0] arg);
		int k;
		k = 0;
		// One edge passes first, so valid is never lowered and raised in one time step.
		@(negedge core_clk_i);
		while (cmd_ready_o !== 1'b1 && k < 3000) begin
			k++;
			@(negedge core_clk_i);
		end
		cmd_i.valid = 1'b1;
		cmd_i.code = code;
		cmd_i.arg = arg;
		@(negedge core_clk_i);
		cmd_i.valid = 1'b0;
		while (resp_o.valid !== 1'b1 && k < 3000) begin
			k++;
			@(negedge core_clk_i);
		end
		if (k >= 3000) begin
			error_cnt++;
			complete_run();
		end else begin
			rd = resp_o.data;
			rx = resp_o.aux;
			rr = resp_o.range_err;
		end
	endtask

	task automatic t_cond();
		meas_i = 11'h7fe;
		repeat (2) @(negedge core_clk_i);
		send(sts_pkg::CMD_OPER_COND, 0); chk("oper cond", rd, 32'h0321);
		send(sts_pkg::CMD_QUES_COND, 0); chk("ques cond", rd, 32'h1f01);
		send(sts_pkg::CMD_OPER_EVENT, 0); chk("oper event", rd, 32'h0321);
		send(sts_pkg::CMD_OPER_EVENT, 0); chk("oper event cleared", rd, 0);
		send(sts_pkg::CMD_QUES_EVENT, 0); chk("ques event", rd, 32'h0101);
		// Limits fall before the cycle end, yet the earlier failure must still be captured.
		meas_i = 11'h001;
		@(negedge core_clk_i);
		meas_i = 11'h000;
		send(sts_pkg::CMD_QUES_EVENT, 0); chk("limit capture", rd, 32'h1e00);
		send(sts_pkg::CMD_QUES_EVENT, 0); chk("ques event cleared", rd, 0);
		$display("test conditions and events done");
	endtask

	task automatic t_summary();
		send(sts_pkg::CMD_OPER_ENAB_RD, 0); chk("oper enable reset", rd, 0);
		meas_i = 11'h002;
		repeat (3) @(negedge core_clk_i);
		chk("stb masked", stb_o, 8'h00);
		send(sts_pkg::CMD_OPER_ENAB_WR, 32'h0200);
		repeat (3) @(negedge core_clk_i);
		chk("stb oper", stb_o, 8'h80);
		send(sts_pkg::CMD_SRE_WR, 32'h80);
		repeat (3) @(negedge core_clk_i);
		chk("stb rqs", stb_o, 8'hc0);
		send(sts_pkg::CMD_STB_RD, 0); chk("stb query", rd[7:0], 8'hc0);
		meas_i = 11'h402;
		send(sts_pkg::CMD_QUES_ENAB_WR, 32'h0001);
		repeat (3) @(negedge core_clk_i);
		chk("stb ques", stb_o, 8'hc8);
		mav_i = 1'b1;
		std_event_i = 8'h01;
		@(negedge core_clk_i);
		std_event_i = 8'h00;
		send(sts_pkg::CMD_ESE_WR, 32'h01);
		repeat (3) @(negedge core_clk_i);
		chk("stb esb mav", stb_o, 8'hf8);
		send(sts_pkg::CMD_PRESET, 0);
		repeat (3) @(negedge core_clk_i);
		chk("stb after preset", stb_o, 8'h30);
		send(sts_pkg::CMD_OPER_ENAB_RD, 0); chk("oper enable preset", rd, 0);
		send(sts_pkg::CMD_QUES_ENAB_RD, 0); chk("ques enable preset", rd, 0);
		send(sts_pkg::CMD_OPER_EVENT, 0); chk("event kept", rd, 32'h0200);
		send(sts_pkg::CMD_ESR_RD, 0); chk("esr kept", rd[7:0], 8'h01);
		mav_i = 1'b0;
		$display("test summary done");
	endtask

	task automatic t_errq();
		for (int i = 1; i <= 22; i++) begin
			err_i = {16'(i), 8'(i)};
			err_valid_i = 1'b1;
			@(negedge core_clk_i);
		end
		err_valid_i = 1'b0;
		for (int i = 1; i <= 20; i++) begin
			send(sts_pkg::CMD_ERR_RD, 0);
			chk("err num", rd, (i == 20) ? 32'hfffffea2 : 32'(i));
			chk("err msg", rx, (i == 20) ? 32'h1 : 32'(i));
		end
		send(sts_pkg::CMD_ERR_RD, 0); chk("empty num", rd, 0);
		chk("empty msg", rx, 0);
		err_valid_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		err_valid_i = 1'b0;
		send(sts_pkg::CMD_CLS, 0);
		send(sts_pkg::CMD_ERR_RD, 0); chk("cleared queue", rd, 0);
		$display("test error queue done");
	endtask

	task automatic t_test();
		send(sts_pkg::CMD_TEST_NUM, 32'h00020005); chk("repeat fails", rd, 5);
		send(sts_pkg::CMD_TEST_NUM, 32'h005e0001); chk("test 94", rd, 0);
		send(sts_pkg::CMD_TEST_NUM, 32'h005f0001); chk("test 95", 32'(rr), 1);
		send(sts_pkg::CMD_TEST_NUM, 32'h00030000); chk("zero cycles", 32'(rr), 1);
		send(sts_pkg::CMD_SELFTEST, 0); chk("first failure", rd, 2);
		send(sts_pkg::CMD_TST_RESULTS, 3); chk("next failure", rd, 40);
		send(sts_pkg::CMD_TST_RESULTS, 41); chk("no more", rd, 0);
		send(sts_pkg::CMD_TEST_ERR, 32'h00280000); chk("fail mode", rd, 5);
		chk("test param", rx, 32'h00ab0028);
		send(sts_pkg::CMD_VERSION, 0); chk("year", rd[15:0], sts_pkg::VERSION_YEAR);
		chk("revision", rx[3:0], sts_pkg::VERSION_REV);
		$display("test self-test done");
	endtask

	initial begin
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_cond();
		t_summary();
		t_errq();
		t_test();
		complete_run();
	end
endmodule
